// ==== logic/tct_pkg.sv ====
// Purpose: shared constants of the two-channel timer register block
// Assumes: apb register word index = paddr[7:2]; byte address = 4 * index
// Notes:   offsets, field positions, codes and multi-bit reset values used by tct_timer live here once
package tct_pkg;

   // register word indices (byte address is four times the index)
   localparam logic [5:0] IDX_MAIN_CTRL  = 6'h10;
   localparam logic [5:0] IDX_COUNT_HI   = 6'h11;
   localparam logic [5:0] IDX_COUNT_LO   = 6'h12;
   localparam logic [5:0] IDX_CH0_CTRL   = 6'h13;
   localparam logic [5:0] IDX_PERIOD_HI  = 6'h14;
   localparam logic [5:0] IDX_PERIOD_LO  = 6'h15;
   localparam logic [5:0] IDX_CH1_CTRL   = 6'h16;
   localparam logic [5:0] IDX_CH0_CMP_HI = 6'h18;
   localparam logic [5:0] IDX_CH0_CMP_LO = 6'h19;
   localparam logic [5:0] IDX_CH1_CMP_HI = 6'h1A;
   localparam logic [5:0] IDX_CH1_CMP_LO = 6'h1B;

   // main control field positions
   localparam int MC_FLAG   = 7;
   localparam int MC_IE     = 6;
   localparam int MC_HALT   = 5;
   localparam int MC_CLEAR  = 4;
   localparam int MC_PS_LSB = 0;
   localparam int MC_PS_MSB = 2;

   // channel control field positions
   localparam int CC_FLAG = 7;
   localparam int CC_IE   = 6;
   localparam int CC_BUF  = 5;
   localparam int CC_MSA  = 4;
   localparam int CC_ELSB = 3;
   localparam int CC_ELSA = 2;
   localparam int CC_TOV  = 1;
   localparam int CC_MAX  = 0;

   // reset values
   localparam logic [2:0]  PS_RESET     = 3'h0;
   localparam logic [15:0] COUNT_RESET  = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
   localparam logic [1:0]  ELS_RESET    = 2'h0;
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;

   // prescaler codes
   localparam logic [2:0] PS_EXT_PIN = 3'h7;
   localparam int         DIV_BITS   = 6;

   // edge/level select codes: capture trigger or compare action
   localparam logic [1:0] ELS_OFF  = 2'h0;
   localparam logic [1:0] ELS_RISE = 2'h1;
   localparam logic [1:0] ELS_FALL = 2'h2;
   localparam logic [1:0] ELS_BOTH = 2'h3;

   // compare actions share the edge codes
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_SET    = 2'h3;

endpackage

// ==== logic/tct_prescaler.sv ====
// Purpose: counter clock enable from bus clock divider or external pin
// Assumes: external pin is asynchronous; pulse width above two bus clocks
// Notes:   output is a one-cycle enable, never a derived clock
`timescale 1ns/100ps
module tct_prescaler (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       reset_in,
   // control
   input  wire logic       clear_in,
   input  wire logic [2:0] select_in,
   // external timer clock pin
   input  wire logic       ext_clk_in,
   // enable out
   output logic            tick_out
);

   logic [tct_pkg::DIV_BITS-1:0] div_q;
   logic [tct_pkg::DIV_BITS-1:0] div_mask;
   logic                         ext_meta_q;
   logic                         ext_sync_q;
   logic                         ext_prev_q;
   logic                         div_tick;

   // free-running divider, zeroed by the clear bit
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         div_q <= '0;
      end else if (clear_in) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_meta_q <= ext_clk_in;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end

   // divide by two to the select
   always_comb begin
      div_mask = tct_pkg::DIV_BITS'((7'h01 << select_in) - 7'h01);
      div_tick = ((div_q & div_mask) == div_mask);
   end

   assign tick_out = (select_in == tct_pkg::PS_EXT_PIN) ? (ext_sync_q & ~ext_prev_q)
                                                        : (div_tick & ~clear_in);

endmodule

// ==== logic/tct_timer.sv ====
// Purpose: register block and counter of a two-channel 16-bit timer on apb
// Assumes: pready always high, so every access ends in its first access cycle
// Notes:   byte-wide registers sit in the low bits of each apb word
//
// Contract
// - overflow flag sets when count equals period
// - flag clears by read-then-write-zero only
// - overflow irq when flag and enable set
// - halt bit freezes counter, set at reset
// - halted counter blocks channel captures
// - clear bit zeroes counter and prescaler
// - halt plus clear leaves counter zero
// - select picks divider or external pin
// - high read latches low byte once
// - counter zero on reset and clear
// - count wraps to zero after period
// - period high write blocks overflow until low
// - period resets to all ones
// - channel flag on capture edge or match
// - channel flag read-then-write-zero clear
// - channel irq when flag and enable
// - buffered bit disables channel one
// - low mode bit picks compare or capture
// - low mode bit presets idle pin level
// - edge field selects trigger or action
// - toggle pin on wrap in compare
// - wrap action beats same-cycle compare
// - compare high write blocks matches until low
`timescale 1ns/100ps
module tct_timer (
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        reset_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // timer pins
   input  wire logic        external_timer_clock_pin_in,
   input  wire logic [1:0]  channel_pin_in,
   output logic      [1:0]  channel_pin_out,
   output logic      [1:0]  channel_pin_oe_out,
   // interrupt requests
   output logic             overflow_irq_out,
   output logic      [1:0]  channel_irq_out
);
   // register decode shared by every read and write path
   function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
      return (addr[7:2] == idx) && (addr[1:0] == 2'b00);
   endfunction
   logic        access;
   logic        main_hit;
   logic        wr_acc;
   logic        rd_acc;
   logic [7:0]  wbyte;
   logic        mapped;
   logic [7:0]  rd_byte;
   logic        overflow_flag_q;
   logic        ovf_armed_q;
   logic        overflow_irq_enable_q;
   logic        counter_halt_q;
   logic [2:0]  clock_divider_select_q;
   logic [15:0] count_q;
   logic [15:0] period_q;
   logic        period_inhibit_q;
   logic [7:0]  low_latch_q;
   logic        latched_q;
   logic        buffered_mode_select_q;
   logic        clear_pulse;
   logic        tick;
   logic        step;
   logic        wrap;
   logic        ovf_event;
   logic [1:0]  ch_flag_q;
   logic [1:0]  ch_armed_q;
   logic [1:0]  ch_ie_q;
   logic [1:0]  ch_msa_q;
   logic [1:0]  ch_els_q [2];
   logic [1:0]  ch_tov_q;
   logic [1:0]  ch_max_q;
   logic [15:0] ch_cmp_q [2];
   logic [1:0]  ch_cmp_inhibit_q;
   logic [1:0]  ch_pin_q;
   logic [1:0]  ch_meta_q;
   logic [1:0]  ch_sync_q;
   logic [1:0]  ch_prev_q;
   logic [7:0]  ch_ctl_rd [2];
   // apb strobes; zero-wait slave
   assign access     = psel_in & penable_in;
   assign wr_acc     = access & pwrite_in;
   assign rd_acc     = access & ~pwrite_in;
   assign wbyte      = pwdata_in[7:0];
   assign pready_out = 1'b1;
   assign main_hit   = reg_hit(paddr_in, tct_pkg::IDX_MAIN_CTRL);
   assign clear_pulse = wr_acc & main_hit & wbyte[tct_pkg::MC_CLEAR];
   tct_prescaler u_prescaler (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .clear_in    (clear_pulse),
      .select_in   (clock_divider_select_q),
      .ext_clk_in  (external_timer_clock_pin_in),
      .tick_out    (tick)
   );
   // counting step when running and not cleared
   assign step      = tick & ~counter_halt_q & ~clear_pulse;
   assign wrap      = step & (count_q == period_q);
   assign ovf_event = wrap & ~period_inhibit_q;
   // counter: clear wins, then wrap, then increment
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         count_q <= tct_pkg::COUNT_RESET;
      end else if (clear_pulse || wrap) begin
         count_q <= tct_pkg::COUNT_RESET;
      end else if (step) begin
         count_q <= count_q + 16'h0001;
      end
   end
   // main control fields; halt set out of reset
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         overflow_irq_enable_q  <= 1'b0;
         counter_halt_q         <= 1'b1;
         clock_divider_select_q <= tct_pkg::PS_RESET;
      end else if (wr_acc && main_hit) begin
         overflow_irq_enable_q  <= wbyte[tct_pkg::MC_IE];
         // halt bit stored; follows since clear still acts
         counter_halt_q         <= wbyte[tct_pkg::MC_HALT];
         clock_divider_select_q <= wbyte[tct_pkg::MC_PS_MSB:tct_pkg::MC_PS_LSB];
      end
   end
   // overflow flag; set beats clear in the same cycle
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         overflow_flag_q <= 1'b0;
         ovf_armed_q     <= 1'b0;
      end else if (ovf_event) begin
         overflow_flag_q <= 1'b1;
         ovf_armed_q     <= 1'b0;
      end else if (rd_acc && main_hit && overflow_flag_q) begin
         ovf_armed_q <= 1'b1;
      end else if (wr_acc && main_hit) begin
         // zero clears only after an arming read; one does nothing
         if (ovf_armed_q && !wbyte[tct_pkg::MC_FLAG]) begin
            overflow_flag_q <= 1'b0;
         end
         ovf_armed_q <= 1'b0;
      end
   end
   assign overflow_irq_out = overflow_flag_q & overflow_irq_enable_q;
   // low byte latch on high read, released by low read
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         low_latch_q <= tct_pkg::BYTE_ZERO;
         latched_q   <= 1'b0;
      end else if (clear_pulse) begin
         latched_q <= 1'b0;
      end else if (rd_acc && reg_hit(paddr_in, tct_pkg::IDX_COUNT_HI) && !latched_q) begin
         low_latch_q <= count_q[7:0];
         latched_q   <= 1'b1;
      end else if (rd_acc && reg_hit(paddr_in, tct_pkg::IDX_COUNT_LO)) begin
         latched_q <= 1'b0;
      end
   end
   // period register; software should clear counter first, not enforced
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         period_q         <= tct_pkg::PERIOD_RESET;
         period_inhibit_q <= 1'b0;
      end else if (wr_acc && reg_hit(paddr_in, tct_pkg::IDX_PERIOD_HI)) begin
         // high write opens the inhibit window
         period_q[15:8]   <= wbyte;
         period_inhibit_q <= 1'b1;
      end else if (wr_acc && reg_hit(paddr_in, tct_pkg::IDX_PERIOD_LO)) begin
         period_q[7:0]    <= wbyte;
         period_inhibit_q <= 1'b0;
      end
   end
   // buffered mode bit lives in channel 0 only
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         buffered_mode_select_q <= 1'b0;
      end else if (wr_acc && reg_hit(paddr_in, tct_pkg::IDX_CH0_CTRL)) begin
         buffered_mode_select_q <= wbyte[tct_pkg::CC_BUF];
      end
   end
   // per-channel logic
   generate
      for (genvar gi = 0; gi < 2; gi++) begin : g_ch
         localparam logic [5:0] CTRL_IDX = (gi == 0) ? tct_pkg::IDX_CH0_CTRL
                                                     : tct_pkg::IDX_CH1_CTRL;
         localparam logic [5:0] HI_IDX   = (gi == 0) ? tct_pkg::IDX_CH0_CMP_HI
                                                     : tct_pkg::IDX_CH1_CMP_HI;
         localparam logic [5:0] LO_IDX   = (gi == 0) ? tct_pkg::IDX_CH0_CMP_LO
                                                     : tct_pkg::IDX_CH1_CMP_LO;
         logic active;
         logic buf_here;
         logic cap_mode;
         logic cmp_mode;
         logic rise;
         logic fall;
         logic cap_event;
         logic match;
         logic wrap_hit;
         logic ctl_wr;
         logic ctl_rd;
         // channel 1 idle while buffered mode is on
         assign active   = (gi == 0) | ~buffered_mode_select_q;
         assign buf_here = (gi == 0) & buffered_mode_select_q;
         assign ctl_wr   = wr_acc & reg_hit(paddr_in, CTRL_IDX) & active;
         assign ctl_rd   = rd_acc & reg_hit(paddr_in, CTRL_IDX) & active;
         // low mode bit chooses capture or compare
         assign cap_mode = active & (ch_els_q[gi] != tct_pkg::ELS_OFF) & ~ch_msa_q[gi] & ~buf_here;
         assign cmp_mode = active & (ch_els_q[gi] != tct_pkg::ELS_OFF) & (ch_msa_q[gi] | buf_here);
         // pin synchroniser; edge detect compares second and third stages
         always_ff @(posedge core_clk_in or posedge reset_in) begin
            if (reset_in) begin
               ch_meta_q[gi] <= 1'b0;
               ch_sync_q[gi] <= 1'b0;
               ch_prev_q[gi] <= 1'b0;
            end else begin
               ch_meta_q[gi] <= channel_pin_in[gi];
               ch_sync_q[gi] <= ch_meta_q[gi];
               ch_prev_q[gi] <= ch_sync_q[gi];
            end
         end
         assign rise = ch_sync_q[gi] & ~ch_prev_q[gi];
         assign fall = ~ch_sync_q[gi] & ch_prev_q[gi];
         // trigger edge choice; no capture while halted
         assign cap_event = cap_mode & ~counter_halt_q
                            & ((rise & ch_els_q[gi][0]) | (fall & ch_els_q[gi][1]));
         assign match    = cmp_mode & step & (count_q == ch_cmp_q[gi]) & ~ch_cmp_inhibit_q[gi];
         assign wrap_hit = cmp_mode & ch_tov_q[gi] & wrap;
         // control fields; writes ignored while channel disabled
         always_ff @(posedge core_clk_in or posedge reset_in) begin
            if (reset_in) begin
               ch_ie_q[gi]  <= 1'b0;
               ch_msa_q[gi] <= 1'b0;
               ch_els_q[gi] <= tct_pkg::ELS_RESET;
               ch_tov_q[gi] <= 1'b0;
               ch_max_q[gi] <= 1'b0;
            end else if (ctl_wr) begin
               ch_ie_q[gi]  <= wbyte[tct_pkg::CC_IE];
               ch_msa_q[gi] <= wbyte[tct_pkg::CC_MSA];
               ch_els_q[gi] <= wbyte[tct_pkg::CC_ELSB:tct_pkg::CC_ELSA];
               ch_tov_q[gi] <= wbyte[tct_pkg::CC_TOV];
               ch_max_q[gi] <= wbyte[tct_pkg::CC_MAX];
            end
         end
         // event flag; new event beats the clear
         always_ff @(posedge core_clk_in or posedge reset_in) begin
            if (reset_in) begin
               ch_flag_q[gi]  <= 1'b0;
               ch_armed_q[gi] <= 1'b0;
            end else if (cap_event || match) begin
               ch_flag_q[gi]  <= 1'b1;
               ch_armed_q[gi] <= 1'b0;
            end else if (ctl_rd && ch_flag_q[gi]) begin
               ch_armed_q[gi] <= 1'b1;
            end else if (ctl_wr) begin
               if (ch_armed_q[gi] && !wbyte[tct_pkg::CC_FLAG]) begin
                  ch_flag_q[gi] <= 1'b0;
               end
               ch_armed_q[gi] <= 1'b0;
            end
         end
         // compare value: capture loads it, software writes it by bytes
         always_ff @(posedge core_clk_in or posedge reset_in) begin
            if (reset_in) begin
               ch_cmp_q[gi]         <= tct_pkg::COUNT_RESET;
               ch_cmp_inhibit_q[gi] <= 1'b0;
            end else if (cap_event) begin
               ch_cmp_q[gi] <= count_q;
            end else if (wr_acc && reg_hit(paddr_in, HI_IDX)) begin
               ch_cmp_q[gi][15:8]   <= wbyte;
               // only compare modes hold off matches
               ch_cmp_inhibit_q[gi] <= cmp_mode;
            end else if (wr_acc && reg_hit(paddr_in, LO_IDX)) begin
               ch_cmp_q[gi][7:0]    <= wbyte;
               ch_cmp_inhibit_q[gi] <= 1'b0;
            end
         end
         // output level; idle channels keep the preset level ready
         always_ff @(posedge core_clk_in or posedge reset_in) begin
            if (reset_in) begin
               ch_pin_q[gi] <= 1'b1;
            end else if (!cmp_mode) begin
               // one presets low, zero presets high
               ch_pin_q[gi] <= ~ch_msa_q[gi];
            end else if (ch_max_q[gi] && ch_tov_q[gi]) begin
               ch_pin_q[gi] <= 1'b1;
            end else if (wrap_hit) begin
               // toggle on wrap; compare ignored this cycle
               ch_pin_q[gi] <= ~ch_pin_q[gi];
            end else if (match) begin
               unique case (ch_els_q[gi])
                  tct_pkg::ACT_TOGGLE: ch_pin_q[gi] <= ~ch_pin_q[gi];
                  tct_pkg::ACT_CLEAR:  ch_pin_q[gi] <= 1'b0;
                  tct_pkg::ACT_SET:    ch_pin_q[gi] <= 1'b1;
               endcase
            end
         end
         // pin driven only in compare modes
         assign channel_pin_out[gi]    = ch_pin_q[gi];
         assign channel_pin_oe_out[gi] = cmp_mode;
         // channel request level, silent when idle
         assign channel_irq_out[gi]    = ch_flag_q[gi] & ch_ie_q[gi] & active;
         // readback; disabled channel 1 reads zero
         assign ch_ctl_rd[gi] = active ? {ch_flag_q[gi], ch_ie_q[gi], buf_here,
                                          ch_msa_q[gi], ch_els_q[gi], ch_tov_q[gi],
                                          ch_max_q[gi]}
                                       : tct_pkg::BYTE_ZERO;
      end
   endgenerate
   // read mux; clear bit always reads zero, bit 3 reserved
   always_comb begin
      rd_byte = tct_pkg::BYTE_ZERO;
      mapped  = 1'b1;
      if (main_hit) begin
         rd_byte[tct_pkg::MC_FLAG]                     = overflow_flag_q;
         rd_byte[tct_pkg::MC_IE]                       = overflow_irq_enable_q;
         rd_byte[tct_pkg::MC_HALT]                     = counter_halt_q;
         rd_byte[tct_pkg::MC_PS_MSB:tct_pkg::MC_PS_LSB] = clock_divider_select_q;
      end else if (reg_hit(paddr_in, tct_pkg::IDX_COUNT_HI)) begin
         rd_byte = count_q[15:8];
      end else if (reg_hit(paddr_in, tct_pkg::IDX_COUNT_LO)) begin
         // latched value until the low byte is read
         rd_byte = latched_q ? low_latch_q : count_q[7:0];
      end else if (reg_hit(paddr_in, tct_pkg::IDX_PERIOD_HI)) begin
         rd_byte = period_q[15:8];
      end else if (reg_hit(paddr_in, tct_pkg::IDX_PERIOD_LO)) begin
         rd_byte = period_q[7:0];
      end else if (reg_hit(paddr_in, tct_pkg::IDX_CH0_CTRL)) begin
         rd_byte = ch_ctl_rd[0];
      end else if (reg_hit(paddr_in, tct_pkg::IDX_CH1_CTRL)) begin
         rd_byte = ch_ctl_rd[1];
      end else if (reg_hit(paddr_in, tct_pkg::IDX_CH0_CMP_HI)) begin
         rd_byte = ch_cmp_q[0][15:8];
      end else if (reg_hit(paddr_in, tct_pkg::IDX_CH0_CMP_LO)) begin
         rd_byte = ch_cmp_q[0][7:0];
      end else if (reg_hit(paddr_in, tct_pkg::IDX_CH1_CMP_HI)) begin
         rd_byte = ch_cmp_q[1][15:8];
      end else if (reg_hit(paddr_in, tct_pkg::IDX_CH1_CMP_LO)) begin
         rd_byte = ch_cmp_q[1][7:0];
      end else begin
         mapped = 1'b0;
      end
   end
   // unmapped or misaligned access answers with an error
   assign prdata_out  = {24'h00_0000, rd_byte};
   assign pslverr_out = access & ~mapped;
endmodule

// ==== testbench/tct_timer_monitor.sv ====
// Purpose: port checks of the timer register block
// Assumes: apb accesses end in their first access cycle
// Notes:   bound into tct_timer, reads its ports only
`timescale 1ns/100ps
module tct_timer_mon (
   // clock and reset
   input wire logic        core_clk_in,
   input wire logic        reset_in,
   // apb
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   // pins and requests
   input wire logic [1:0]  channel_pin_oe_out,
   input wire logic        overflow_irq_out,
   input wire logic [1:0]  channel_irq_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // taken accesses, decoded once
   wire logic acc   = psel_in & penable_in;
   wire logic wr_m  = acc & pwrite_in & (paddr_in == {tct_pkg::IDX_MAIN_CTRL, 2'h0});
   wire logic wr_c0 = acc & pwrite_in & (paddr_in == {tct_pkg::IDX_CH0_CTRL, 2'h0});
   wire logic rd_m  = acc & !pwrite_in & (paddr_in == {tct_pkg::IDX_MAIN_CTRL, 2'h0});
   wire logic rd_c1 = acc & !pwrite_in & (paddr_in == {tct_pkg::IDX_CH1_CTRL, 2'h0});
   // a write lands first, its effect follows a cycle later
   sequence s_m_ie_off;  wr_m ##0 !pwdata_in[6];  endsequence
   sequence s_c0_ie_off; wr_c0 ##0 !pwdata_in[6]; endsequence
   sequence s_buf_on;    wr_c0 ##0 pwdata_in[5];  endsequence
   chk_ovf_ie_off: assert property (s_m_ie_off |=> !overflow_irq_out)
      else $error("overflow request after enable off");
   chk_ovf_drop_wr: assert property ($fell(overflow_irq_out) |-> $past(wr_m))
      else $error("overflow request fell without a write");
   chk_ch_ie_off: assert property (s_c0_ie_off |=> !channel_irq_out[0])
      else $error("channel request after enable off");
   chk_ch_drop_wr: assert property ($fell(channel_irq_out[0]) |-> $past(wr_c0))
      else $error("channel request fell without a write");
   chk_clear_reads0: assert property (rd_m |-> !prdata_out[4])
      else $error("clear bit read as one");
   chk_buf_ch1_off: assert property (s_buf_on |=>
      !channel_pin_oe_out[1] && !channel_irq_out[1]) else $error("channel one still active");
   chk_ch1_no_buf: assert property (rd_c1 |-> !prdata_out[5])
      else $error("channel one shows buffered bit");
   chk_reset_quiet: assert property ($fell(reset_in) |->
      !overflow_irq_out && channel_irq_out == 2'h0 && channel_pin_oe_out == 2'h0)
      else $error("outputs active after reset");
endmodule
bind tct_timer tct_timer_mon tct_timer_mon_i (.*);

// ==== testbench/tct_pin_model.sv ====
// Purpose: pin-side partner for the timer clock and channel pins
// Assumes: tasks are called from one bench process
// Notes:   pins are always driven, never released
`timescale 1ns/100ps
module tct_pin_model (
   // clock
   input  wire logic  core_clk_in,
   // pins towards the timer
   output logic       ext_clk_out,
   output logic [1:0] ch_pin_out
);
   // quiet pins from time zero
   initial begin
      ext_clk_out = 1'h0;
      ch_pin_out  = 2'h0;
   end
   // pulses three bus clocks each way
   task automatic ext_pulses(input int n);
      repeat (n) begin
         @(posedge core_clk_in);
         ext_clk_out <= 1'h1;
         repeat (3) @(posedge core_clk_in);
         ext_clk_out <= 1'h0;
         repeat (2) @(posedge core_clk_in);
      end
   endtask
   // level held past sync and edge stage
   task automatic set_pin(input int ch, input logic v);
      @(posedge core_clk_in);
      ch_pin_out[ch] <= v;
      repeat (5) @(posedge core_clk_in);
   endtask
endmodule

// ==== testbench/tct_timer_bench.sv ====
// Purpose: self-checking bench of the timer register block
// Assumes: pin model supplies clock pulses and channel edges
// Notes:   counts are read halted so they can be predicted
`timescale 1ns/100ps
module tct_timer_bench;
   logic        core_clk_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, er;
   logic        pslverr_out, external_timer_clock_pin_in, overflow_irq_out;
   logic [7:0]  paddr_in, rv, cf;
   logic [31:0] pwdata_in, prdata_out;
   logic [1:0]  channel_pin_in, channel_pin_out, channel_pin_oe_out, channel_irq_out;
   logic [15:0] c;
   int          n_fail, compares, cyc;
   localparam logic [5:0] IM = tct_pkg::IDX_MAIN_CTRL, IH = tct_pkg::IDX_COUNT_HI,
      IL = tct_pkg::IDX_COUNT_LO, IC0 = tct_pkg::IDX_CH0_CTRL, IC1 = tct_pkg::IDX_CH1_CTRL,
      IPH = tct_pkg::IDX_PERIOD_HI, IPL = tct_pkg::IDX_PERIOD_LO;
   tct_timer tct_timer_i (.*);
   tct_pin_model tct_pin_model_i (.core_clk_in(core_clk_in),
      .ext_clk_out(external_timer_clock_pin_in), .ch_pin_out(channel_pin_in));
   // bus clock
   initial begin
      core_clk_in = 1'h0;
      forever #10 core_clk_in = ~core_clk_in;
   end
   // hang guard, far above the cycles used
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 8000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic test_done();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // one transfer; data taken at the edge that sees pready
   task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
      @(posedge core_clk_in);
      psel_in   <= 1'h1;
      pwrite_in <= w;
      paddr_in  <= {i, 2'h0};
      pwdata_in <= {24'h00_0000, d};
      @(posedge core_clk_in);
      penable_in <= 1'h1;
      do @(posedge core_clk_in); while (pready_out !== 1'h1);
      rv = prdata_out[7:0];
      er = pslverr_out;
      psel_in    <= 1'h0;
      penable_in <= 1'h0;
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      apb(1'h1, i, d);
   endtask
   task automatic rdc(input string n, input logic [5:0] i, input logic [7:0] e);
      apb(1'h0, i, 8'h00);
      chk(n, 16'(e), 16'(rv));
   endtask
   // high byte first, it holds the low byte
   task automatic rdcnt();
      apb(1'h0, IH, 8'h00);
      c[15:8] = rv;
      apb(1'h0, IL, 8'h00);
      c[7:0] = rv;
   endtask
   task automatic t_reset();
      logic [5:0] ix [7] = '{IM, IH, IL, IPH, IPL, IC0, IC1};
      logic [7:0] ev [7] = '{8'h20, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
      for (int k = 0; k < 7; k++) rdc("reset value", ix[k], ev[k]);
      apb(1'h0, 6'h00, 8'h00);
      chk("unmapped err", 16'h0001, 16'(er));
   endtask
   task automatic t_ovf();
      wr(IM, 8'h30);
      // counter cleared before a new period
      wr(IPH, 8'h00);
      wr(IPL, 8'h05);
      wr(IM, 8'h40);
      for (int t = 0; t < 40 && overflow_irq_out !== 1'h1; t++) @(posedge core_clk_in);
      wr(IM, 8'h60);
      rdc("main flag", IM, 8'hE0);
      rdcnt();
      chk("wrap", 16'h0001, 16'(c <= 16'h0005));
      wr(IM, 8'hE0);
      rdc("write one", IM, 8'hE0);
      wr(IM, 8'h60);
      rdc("flag clear", IM, 8'h60);
      chk("ovf irq", 16'h0000, 16'(overflow_irq_out));
      wr(IM, 8'h70);
      rdcnt();
      chk("cleared count", 16'h0000, c);
      wr(IPH, 8'hFF);
      wr(IPL, 8'hFF);
   endtask
   // gap of 67 bus clocks between run and halt writes
   task automatic t_rate();
      for (int n = 0; n < 7; n++) begin
         wr(IM, 8'h30);
         wr(IM, 8'(n));
         repeat (64) @(posedge core_clk_in);
         wr(IM, 8'h20 | 8'(n));
         rdcnt();
         chk("div count", 16'h0001, 16'(c + 1 >= (67 >> n) && c <= (67 >> n) + 1));
      end
      wr(IM, 8'h37);
      wr(IM, 8'h07);
      tct_pin_model_i.ext_pulses(5);
      wr(IM, 8'h27);
      rdcnt();
      chk("pin count", 16'h0005, c);
   endtask
   task automatic t_capture();
      wr(IC0, 8'h44);
      tct_pin_model_i.set_pin(0, 1'h1);
      rdc("halted capture", IC0, 8'h44);
      tct_pin_model_i.set_pin(0, 1'h0);
      wr(IM, 8'h00);
      for (int e = 1; e < 4; e++) begin
         cf = 8'h40 | 8'(e << 2);
         wr(IC0, cf);
         tct_pin_model_i.set_pin(0, 1'h1);
         rdc("rise flag", IC0, cf | {e[0], 7'h00});
         chk("ch irq", 16'(e[0]), 16'(channel_irq_out[0]));
         wr(IC0, cf);
         tct_pin_model_i.set_pin(0, 1'h0);
         rdc("fall flag", IC0, cf | {e[1], 7'h00});
         wr(IC0, cf);
         rdc("ch flag clear", IC0, cf);
      end
   endtask
   task automatic t_ch1();
      wr(IC1, 8'h10);
      rdc("ch1 preset", IC1, 8'h10);
      chk("preset low", 16'h0000, 16'(channel_pin_out[1]));
      wr(IC1, 8'h14);
      rdc("ch1 compare", IC1, 8'h14);
      chk("compare oe", 16'h0001, 16'(channel_pin_oe_out[1]));
      wr(IC0, 8'h20);
      rdc("ch1 off", IC1, 8'h00);
   endtask
   // reset, then scenarios in turn
   initial begin
      reset_in   = 1'h1;
      psel_in    = 1'h0;
      penable_in = 1'h0;
      pwrite_in  = 1'h0;
      paddr_in   = 8'h00;
      pwdata_in  = 32'h0000_0000;
      repeat (12) @(posedge core_clk_in);
      reset_in <= 1'h0;
      t_reset();
      t_ovf();
      t_rate();
      t_capture();
      t_ch1();
      test_done();
   end
endmodule
